// [hdl/sad_pkg.sv]
/*
  Shared constants for the servo axis drive block: register map, field
  positions, reset values, timing counts and the commutation sine table.
  Assumes a 20 MHz servo clock and a 16-bit signed drive DAC code.
*/
package sad_pkg;
  localparam int NUM_AXES_DEF = 4;
  localparam int ADDR_W = 8;
  localparam int POS_W = 32;
  localparam int DAC_W = 16;
  localparam int CLK_PERIOD_NS = 50;
  localparam int SERVO_SAMPLE_NS = 250000;
  localparam int SERVO_TICK_DEF = SERVO_SAMPLE_NS / CLK_PERIOD_NS;
  localparam logic [DAC_W-1:0] DAC_FULL_CODE = 16'h7FFF;
  localparam int FULL_SCALE_MV = 10000;
  localparam int CLAMP_RESET_MV = 9990;
  localparam logic [DAC_W-1:0] CLAMP_RESET_CODE = DAC_W'((CLAMP_RESET_MV * int'(DAC_FULL_CODE)) / FULL_SCALE_MV);
  localparam logic [POS_W-1:0] LAG_LIMIT_RESET = 32'h0000_07D0;
  // global registers
  localparam logic [ADDR_W-1:0] A_IRQ_STAT = 8'h00;
  localparam logic [ADDR_W-1:0] A_IRQ_MASK = 8'h04;
  localparam logic [ADDR_W-1:0] A_COMM = 8'h08;
  localparam logic [ADDR_W-1:0] A_NV_SAVE = 8'h0C;
  localparam logic [ADDR_W-1:0] A_CMD = 8'h10;
  localparam logic [ADDR_W-1:0] A_AXIS_BASE = 8'h40;
  localparam int AXIS_STRIDE_SH = 5;
  // per-axis registers, offset inside the axis window
  localparam logic [4:0] O_CTRL = 5'h00;
  localparam logic [4:0] O_LAG = 5'h04;
  localparam logic [4:0] O_CLAMP = 5'h08;
  localparam logic [4:0] O_DIST = 5'h0C;
  localparam logic [4:0] O_KPD = 5'h10;
  localparam logic [4:0] O_KI = 5'h14;
  localparam logic [4:0] O_LEVEL = 5'h18;
  localparam logic [4:0] O_POS = 5'h1C;
  localparam int CTRL_FAULT_DIS = 0;
  localparam int CTRL_LOOP_INV = 1;
  localparam int CTRL_ENC_INV = 2;
  localparam int CTRL_W = 3;
  localparam int CMD_LAUNCH_LSB = 0;
  localparam int CMD_OFF_LSB = 4;
  localparam int CMD_HOLD_LSB = 8;
  localparam int COMM_SIN_LSB = 0;
  localparam int COMM_SHIFT_LSB = 4;
  localparam int COMM_OFS_LSB = 16;
  localparam int NV_SAVE_BIT = 0;
  localparam int IRQ_WDOG_BIT = 4;
  localparam int IRQ_W = 5;
  localparam int KD_LSB = 16;
  // commutation angle: 32 steps per magnetic cycle
  localparam int ANGLE_W = 5;
  localparam int SHIFT_W = 5;
  localparam logic [ANGLE_W-1:0] PHASE_B_STEPS = 5'h0B;
  localparam int SINE_FRAC = 15;
  localparam int PID_SHIFT = 8;
  localparam int ERR_SAT_W = 24;

  function automatic logic signed [DAC_W-1:0] sine_q15(input logic [ANGLE_W-1:0] ang);
    logic [3:0] idx;
    logic [DAC_W-1:0] mag;
    idx = ang[3] ? 4'(4'h8 - {1'b0, ang[2:0]}) : {1'b0, ang[2:0]};
    if (ang[3] && ang[2:0] == 3'h0) begin
      idx = 4'h8;
    end
    case (idx)
      4'h0: mag = 16'h0000;
      4'h1: mag = 16'h18F9;
      4'h2: mag = 16'h30FC;
      4'h3: mag = 16'h471D;
      4'h4: mag = 16'h5A82;
      4'h5: mag = 16'h6A6E;
      4'h6: mag = 16'h7642;
      4'h7: mag = 16'h7D8A;
      default: mag = DAC_FULL_CODE;
    endcase
    sine_q15 = ang[4] ? -$signed(mag) : $signed(mag);
  endfunction
endpackage

// [hdl/sad_pid_if.sv]
/*
  Carrier between the axis control logic and one position filter.
  Assumes both ends run on the same servo clock.
*/
`timescale 1ns/1ps
interface sad_pid_if;
  logic tick;
  logic clear;
  logic signed [31:0] err;
  logic [15:0] kp;
  logic [15:0] kd;
  logic [15:0] ki;
  logic signed [15:0] u;
  modport ctl(output tick, output clear, output err, output kp, output kd, output ki, input u);
  modport filt(input tick, input clear, input err, input kp, input kd, input ki, output u);
endinterface

// [hdl/sad_quad_decoder.sv]
/*
  Quadrature encoder counter for one axis.
  Assumes asynchronous A/B pins; both pass two flip-flops before decoding.
*/
`timescale 1ns/1ps
module sad_quad_decoder import sad_pkg::*; (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // encoder pins and options
  input wire logic i_enc_a,
  input wire logic i_enc_b,
  input wire logic i_invert,
  // count
  output logic [POS_W-1:0] o_position
);
  logic [1:0] ab_s1_q;
  logic [1:0] ab_s2_q;
  logic [1:0] ab_prev_q;
  logic step;
  logic up;

  always_ff @(posedge i_clk) begin
    ab_s1_q <= {i_enc_a, i_enc_b};
    ab_s2_q <= ab_s1_q;
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ab_prev_q <= 2'h0;
    end else begin
      ab_prev_q <= ab_s2_q;
    end
  end

  // double transitions are dropped: they carry no direction
  assign step = (ab_s2_q[1] ^ ab_prev_q[1]) ^ (ab_s2_q[0] ^ ab_prev_q[0]);
  assign up = (ab_s2_q[1] ^ ab_prev_q[0]) ^ i_invert; // RQ10

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_position <= '0;
    end else if (step) begin
      o_position <= up ? o_position + 32'h1 : o_position - 32'h1;
    end
  end
endmodule

// [hdl/sad_pid_filter.sv]
/*
  Proportional, derivative and integral filter for one axis.
  Assumes err is valid when tick pulses; output updates once per tick.
*/
`timescale 1ns/1ps
module sad_pid_filter import sad_pkg::*; (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // filter carrier
  sad_pid_if.filt pid
);
  logic signed [ERR_SAT_W-1:0] e_sat;
  logic signed [ERR_SAT_W-1:0] prev_q;
  logic signed [31:0] integ_q;
  logic signed [32:0] integ_sum;
  logic signed [51:0] acc;
  logic signed [51:0] scaled;
  logic signed [15:0] u_q;

  always_comb begin
    if (pid.err > 32'sh007F_FFFF) begin
      e_sat = 24'sh7F_FFFF;
    end else if (pid.err < -32'sh0080_0000) begin
      e_sat = -24'sh80_0000;
    end else begin
      e_sat = pid.err[ERR_SAT_W-1:0];
    end
    integ_sum = 33'(integ_q) + 33'(e_sat);
    acc = 52'(e_sat * $signed({1'b0, pid.kp}))
        + 52'((25'(e_sat) - 25'(prev_q)) * $signed({1'b0, pid.kd}))
        + 52'(integ_q * $signed({1'b0, pid.ki})); // RQ12
    scaled = acc >>> PID_SHIFT;
  end

  always_ff @(posedge i_clk) begin
    if (i_reset || pid.clear) begin
      prev_q <= '0;
      integ_q <= '0;
      u_q <= '0;
    end else if (pid.tick) begin
      prev_q <= e_sat;
      // saturate rather than wrap, so windup never flips sign
      if (integ_sum[32] != integ_sum[31]) begin
        integ_q <= integ_sum[32] ? 32'sh8000_0000 : 32'sh7FFF_FFFF;
      end else begin
        integ_q <= integ_sum[31:0];
      end
      if (scaled > 52'sh7FFF) begin
        u_q <= 16'sh7FFF;
      end else if (scaled < -52'sh8000) begin
        u_q <= -16'sh8000;
      end else begin
        u_q <= scaled[15:0];
      end
    end
  end

  assign pid.u = u_q;
endmodule

// [hdl/sad_axis_drive.sv]
/*
  Per-axis servo output and safety logic: following-error trip, drive
  clamp, enable control, relative moves, PID, two-phase commutation
  output mapping, register port and interrupt.
  Assumes encoder and watchdog pins are asynchronous, register port is
  on i_clk, and a non-volatile store presents its saved word on i_nv_comm.
  Register field packing allows at most four axes.
*/
// The plain strobed port and the address map were chosen for this implementation.
// Notes on behaviour
// RQ1: each axis holds a following-error limit in encoder counts, default 2000.
// RQ2: with fault-disable set, error beyond limit drops that axis amplifier enable.
// RQ3: drive command magnitude is clamped to the programmed drive clamp.
// RQ4: drive clamp resets to the 9.99 volt code.
// RQ5: drive-off command drops that axis amplifier enable.
// RQ6: relative distance is stored; motion starts only on motion launch.
// RQ7: drive level readback returns the present drive command of the axis; code returns out_q, phase one or a phase two under commutation.
// RQ8: sinusoidal axis drives phase one locally, phase two on highest freed output.
// RQ9: several sinusoidal axes take freed outputs in ascending order.
// RQ10: software bits invert loop polarity and encoder count direction.
// RQ11: commutation settings survive reset and are saved to non-volatile store.
// RQ12: drive command comes from a PID filter with programmable gains.
// RQ13: amplifier enable is active high.
// RQ14: enable drops on watchdog, drive-off, or following-error fault.
// RQ15: error is commanded minus measured, magnitude checked on every servo update; code checks it only while the axis enable is set.
`timescale 1ns/1ps
module sad_axis_drive import sad_pkg::*; #(
  parameter int NUM_AXES = NUM_AXES_DEF,
  parameter int SERVO_TICK_CYCLES = SERVO_TICK_DEF
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // encoder pins
  input wire logic [NUM_AXES-1:0] i_enc_a,
  input wire logic [NUM_AXES-1:0] i_enc_b,
  // watchdog pin
  input wire logic i_watchdog_trip,
  // amplifier side
  output logic [NUM_AXES-1:0] o_drive_permit_out,
  output logic [NUM_AXES-1:0][DAC_W-1:0] o_analog_drive_out,
  // non-volatile store
  input wire logic [31:0] i_nv_comm,
  output logic o_nv_write,
  output logic [31:0] o_nv_comm,
  // interrupt
  output logic o_irq
);
  localparam int TICK_W = $clog2(SERVO_TICK_CYCLES + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(SERVO_TICK_CYCLES - 1);

  function automatic logic axis_hit(input logic [ADDR_W-1:0] addr, input int ax, input logic [4:0] ofs);
    axis_hit = addr == ADDR_W'(int'(A_AXIS_BASE) + (ax << AXIS_STRIDE_SH) + int'(ofs));
  endfunction

  function automatic logic [POS_W-1:0] abs32(input logic signed [POS_W-1:0] v);
    abs32 = v[POS_W-1] ? POS_W'(-v) : v;
  endfunction

  // registers
  logic [TICK_W-1:0] tick_cnt_q;
  logic servo_tick;
  logic wdog_s1_q;
  logic wdog_s2_q;
  logic wdog_prev_q;
  logic wdog_event;
  logic [NUM_AXES-1:0][CTRL_W-1:0] ctrl_q;
  logic [NUM_AXES-1:0][POS_W-1:0] lag_q;
  logic [NUM_AXES-1:0][DAC_W-1:0] clamp_q;
  logic [NUM_AXES-1:0][POS_W-1:0] dist_q;
  logic [NUM_AXES-1:0][15:0] kp_q;
  logic [NUM_AXES-1:0][15:0] kd_q;
  logic [NUM_AXES-1:0][15:0] ki_q;
  logic [NUM_AXES-1:0][POS_W-1:0] target_q;
  logic [NUM_AXES-1:0] enable_q;
  logic [NUM_AXES-1:0] over_limit_q;
  logic [NUM_AXES-1:0][DAC_W-1:0] level_q;
  logic [NUM_AXES-1:0][DAC_W-1:0] out_q;
  logic [NUM_AXES-1:0][DAC_W-1:0] out_d;
  logic [31:0] comm_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] irq_set;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic nv_write_q;
  // derived
  logic [NUM_AXES-1:0][POS_W-1:0] pos;
  logic [NUM_AXES-1:0][POS_W-1:0] err;
  logic [NUM_AXES-1:0] over_limit;
  logic [NUM_AXES-1:0] cmd_launch;
  logic [NUM_AXES-1:0] cmd_off;
  logic [NUM_AXES-1:0] cmd_hold;
  logic [NUM_AXES-1:0] sin_mask;
  logic [NUM_AXES-1:0][DAC_W-1:0] phase_a;
  logic [NUM_AXES-1:0][DAC_W-1:0] phase_b;
  logic [NUM_AXES-1:0][DAC_W-1:0] level_d;
  logic [NUM_AXES-1:0][DAC_W-1:0] filt_u;

  sad_pid_if pid_bus[NUM_AXES] ();

  // servo update strobe
  always_ff @(posedge i_clk) begin
    if (i_reset || tick_cnt_q == TICK_LAST) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + TICK_W'(1);
    end
  end
  assign servo_tick = tick_cnt_q == TICK_LAST;

  // watchdog pin: two flops, then edge detect on the second
  always_ff @(posedge i_clk) begin
    wdog_s1_q <= i_watchdog_trip;
    wdog_s2_q <= wdog_s1_q;
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wdog_prev_q <= 1'b0;
    end else begin
      wdog_prev_q <= wdog_s2_q;
    end
  end
  assign wdog_event = wdog_s2_q && !wdog_prev_q;

  // command strobes from the command register
  always_comb begin
    for (int a = 0; a < NUM_AXES; a++) begin
      cmd_launch[a] = i_wr && i_addr == A_CMD && i_wdata[CMD_LAUNCH_LSB + a];
      cmd_off[a] = i_wr && i_addr == A_CMD && i_wdata[CMD_OFF_LSB + a];
      cmd_hold[a] = i_wr && i_addr == A_CMD && i_wdata[CMD_HOLD_LSB + a];
      sin_mask[a] = comm_q[COMM_SIN_LSB + a];
    end
  end

  // per-axis encoder and filter
  for (genvar g = 0; g < NUM_AXES; g++) begin : g_axis
    sad_quad_decoder u_enc (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_enc_a(i_enc_a[g]),
      .i_enc_b(i_enc_b[g]),
      .i_invert(ctrl_q[g][CTRL_ENC_INV]),
      .o_position(pos[g])
    );
    sad_pid_filter u_pid (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .pid(pid_bus[g])
    );
    assign pid_bus[g].tick = servo_tick;
    // a disabled axis must not wind up its integrator
    assign pid_bus[g].clear = !enable_q[g];
    assign pid_bus[g].err = $signed(err[g]);
    assign pid_bus[g].kp = kp_q[g];
    assign pid_bus[g].kd = kd_q[g];
    assign pid_bus[g].ki = ki_q[g];
    assign filt_u[g] = pid_bus[g].u;
  end

  // following error
  always_comb begin
    for (int a = 0; a < NUM_AXES; a++) begin
      err[a] = target_q[a] - pos[a]; // RQ15
      over_limit[a] = abs32(err[a]) > lag_q[a]; // RQ1
    end
  end

  // software-written axis settings
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      for (int a = 0; a < NUM_AXES; a++) begin
        ctrl_q[a] <= '0;
        lag_q[a] <= LAG_LIMIT_RESET; // RQ1
        clamp_q[a] <= CLAMP_RESET_CODE; // RQ4
        dist_q[a] <= '0;
        kp_q[a] <= '0;
        kd_q[a] <= '0;
        ki_q[a] <= '0;
      end
    end else if (i_wr) begin
      for (int a = 0; a < NUM_AXES; a++) begin
        if (axis_hit(i_addr, a, O_CTRL)) begin
          ctrl_q[a] <= i_wdata[CTRL_W-1:0]; // RQ10
        end
        if (axis_hit(i_addr, a, O_LAG)) begin
          lag_q[a] <= i_wdata;
        end
        if (axis_hit(i_addr, a, O_CLAMP)) begin
          // magnitude only; the top code bit would make a negative limit
          clamp_q[a] <= i_wdata[DAC_W-1:0] & DAC_FULL_CODE;
        end
        if (axis_hit(i_addr, a, O_DIST)) begin
          dist_q[a] <= i_wdata; // RQ6
        end
        if (axis_hit(i_addr, a, O_KPD)) begin
          kp_q[a] <= i_wdata[15:0];
          kd_q[a] <= i_wdata[KD_LSB +: 16];
        end
        if (axis_hit(i_addr, a, O_KI)) begin
          ki_q[a] <= i_wdata[15:0];
        end
      end
    end
  end

  // commanded position: hold takes the present position, launch adds the distance
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      target_q <= '0;
    end else begin
      for (int a = 0; a < NUM_AXES; a++) begin
        if (cmd_hold[a]) begin
          target_q[a] <= pos[a];
        end else if (cmd_launch[a]) begin
          target_q[a] <= target_q[a] + dist_q[a]; // RQ6
        end
      end
    end
  end

  // limit check once per servo update
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      over_limit_q <= '0;
    end else begin
      for (int a = 0; a < NUM_AXES; a++) begin
        over_limit_q[a] <= servo_tick && enable_q[a] && over_limit[a]; // RQ15
      end
    end
  end

  // amplifier enable; every disable cause outranks servo hold
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      enable_q <= '0;
    end else begin
      for (int a = 0; a < NUM_AXES; a++) begin
        if (wdog_s2_q) begin
          enable_q[a] <= 1'b0; // RQ14
        end else if (cmd_off[a]) begin
          enable_q[a] <= 1'b0; // RQ5
        end else if (over_limit_q[a] && ctrl_q[a][CTRL_FAULT_DIS]) begin
          enable_q[a] <= 1'b0; // RQ2
        end else if (cmd_hold[a]) begin
          enable_q[a] <= 1'b1;
        end
      end
    end
  end
  assign o_drive_permit_out = enable_q; // RQ13

  // filter output: polarity, clamp, zero while disabled
  always_comb begin
    for (int a = 0; a < NUM_AXES; a++) begin
      logic signed [DAC_W:0] raw;
      logic signed [DAC_W:0] lim;
      raw = ctrl_q[a][CTRL_LOOP_INV] ? -(DAC_W+1)'($signed(filt_u[a])) : (DAC_W+1)'($signed(filt_u[a])); // RQ10
      lim = $signed({1'b0, clamp_q[a]});
      if (!enable_q[a]) begin
        level_d[a] = '0;
      end else if (raw > lim) begin
        level_d[a] = lim[DAC_W-1:0]; // RQ3
      end else if (raw < -lim) begin
        level_d[a] = DAC_W'(-lim); // RQ3
      end else begin
        level_d[a] = raw[DAC_W-1:0];
      end
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      level_q <= '0;
    end else if (servo_tick || enable_q != {NUM_AXES{1'b1}}) begin
      level_q <= level_d;
    end
  end

  // two-phase commutation from the electrical angle
  always_comb begin
    for (int a = 0; a < NUM_AXES; a++) begin
      logic [ANGLE_W-1:0] ang;
      logic signed [31:0] pa;
      logic signed [31:0] pb;
      ang = ANGLE_W'(pos[a] >> comm_q[COMM_SHIFT_LSB +: SHIFT_W]) + comm_q[COMM_OFS_LSB +: ANGLE_W];
      pa = $signed(level_q[a]) * sine_q15(ang);
      pb = $signed(level_q[a]) * sine_q15(ANGLE_W'(ang + PHASE_B_STEPS));
      phase_a[a] = DAC_W'(pa >>> SINE_FRAC);
      phase_b[a] = DAC_W'(pb >>> SINE_FRAC);
    end
  end

  // output mapping: the top outputs are freed, one per sinusoidal axis
  always_comb begin
    int nsin;
    int rank;
    nsin = 0;
    rank = 0;
    out_d = level_q;
    for (int a = 0; a < NUM_AXES; a++) begin
      nsin = nsin + int'(sin_mask[a]);
    end
    for (int a = 0; a < NUM_AXES; a++) begin
      if (sin_mask[a]) begin
        out_d[a] = phase_a[a]; // RQ8
        out_d[NUM_AXES - nsin + rank] = phase_b[a]; // RQ9
        rank = rank + 1;
      end
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      out_q <= '0;
    end else begin
      out_q <= out_d;
    end
  end
  assign o_analog_drive_out = out_q;

  // commutation word: loaded from the store during reset, not cleared by it
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      comm_q <= i_nv_comm; // RQ11
    end else if (i_wr && i_addr == A_COMM) begin
      comm_q <= i_wdata;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      nv_write_q <= 1'b0;
    end else begin
      nv_write_q <= i_wr && i_addr == A_NV_SAVE && i_wdata[NV_SAVE_BIT]; // RQ11
    end
  end
  assign o_nv_write = nv_write_q;
  assign o_nv_comm = comm_q;

  // interrupt: a new event wins over a same-cycle clear
  always_comb begin
    irq_set = '0;
    irq_set[NUM_AXES-1:0] = over_limit_q;
    irq_set[IRQ_WDOG_BIT] = wdog_event;
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      irq_stat_q <= '0;
    end else if (i_wr && i_addr == A_IRQ_STAT) begin
      irq_stat_q <= (irq_stat_q & ~i_wdata[IRQ_W-1:0]) | irq_set;
    end else begin
      irq_stat_q <= irq_stat_q | irq_set;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      irq_mask_q <= '0;
    end else if (i_wr && i_addr == A_IRQ_MASK) begin
      irq_mask_q <= i_wdata[IRQ_W-1:0];
    end
  end
  assign o_irq = |(irq_stat_q & irq_mask_q);

  // read port; unmapped addresses read zero
  always_comb begin
    rdata_d = '0;
    case (i_addr)
      A_IRQ_STAT: rdata_d = 32'(irq_stat_q);
      A_IRQ_MASK: rdata_d = 32'(irq_mask_q);
      A_COMM: rdata_d = comm_q;
      A_CMD: rdata_d = 32'(enable_q);
      default: begin
        for (int a = 0; a < NUM_AXES; a++) begin
          if (axis_hit(i_addr, a, O_CTRL)) begin
            rdata_d = 32'(ctrl_q[a]);
          end
          if (axis_hit(i_addr, a, O_LAG)) begin
            rdata_d = lag_q[a];
          end
          if (axis_hit(i_addr, a, O_CLAMP)) begin
            rdata_d = 32'(clamp_q[a]);
          end
          if (axis_hit(i_addr, a, O_DIST)) begin
            rdata_d = dist_q[a];
          end
          if (axis_hit(i_addr, a, O_KPD)) begin
            rdata_d = {kd_q[a], kp_q[a]};
          end
          if (axis_hit(i_addr, a, O_KI)) begin
            rdata_d = 32'(ki_q[a]);
          end
          if (axis_hit(i_addr, a, O_LEVEL)) begin
            rdata_d = 32'($signed(out_q[a])); // RQ7
          end
          if (axis_hit(i_addr, a, O_POS)) begin
            rdata_d = pos[a];
          end
        end
      end
    endcase
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= i_rd ? rdata_d : 32'h0000_0000;
    end
  end
  assign o_rdata = rdata_q;
endmodule

// [verification/sad_axis_props.sv]
/*
  Concurrent checks on the ports of sad_axis_drive.
  Assumes it is bound into the design and the clamp is never set above its reset code.
*/
`timescale 1ns/1ps
module sad_axis_props import sad_pkg::*; #(
  parameter int NUM_AXES = 4
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  // pins
  input wire logic i_watchdog_trip,
  input wire logic [NUM_AXES-1:0] o_drive_permit_out,
  input wire logic [NUM_AXES-1:0][DAC_W-1:0] o_analog_drive_out,
  input wire logic [31:0] i_nv_comm,
  input wire logic o_nv_write,
  input wire logic [31:0] o_nv_comm,
  input wire logic o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  wire cmd = i_wr && i_addr == A_CMD;
  wire hold0 = cmd && i_wdata[CMD_HOLD_LSB];
  a_rdata_idle: assert property (!i_rd |=> o_rdata == 32'h0) else $error("read data not idle");
  a_off_drop: assert property (cmd && i_wdata[CMD_OFF_LSB] |=> !o_drive_permit_out[0])
    else $error("permit kept after drive off");
  a_wdog_drop: assert property (i_watchdog_trip [*6] |-> o_drive_permit_out == '0)
    else $error("permit kept under watchdog");
  a_off_zero: assert property (!o_drive_permit_out[0] [*3] |-> o_analog_drive_out[0] == '0)
    else $error("drive while disabled");
  a_drive_range: assert property ($signed(o_analog_drive_out[0]) <= $signed(CLAMP_RESET_CODE) &&
    $signed(o_analog_drive_out[0]) >= -$signed(CLAMP_RESET_CODE)) else $error("drive beyond clamp");
  a_nv_pulse: assert property (i_wr && i_addr == A_NV_SAVE && i_wdata[0] |=> o_nv_write ##1 !o_nv_write)
    else $error("bad save pulse");
  a_nv_load: assert property ($fell(i_reset) |-> o_nv_comm == $past(i_nv_comm))
    else $error("saved word not loaded");
  a_permit_rise: assert property ($rose(o_drive_permit_out[0]) |-> $past(hold0) || $past(hold0, 2))
    else $error("permit rose without hold");
  a_mask_quiet: assert property (i_wr && i_addr == A_IRQ_MASK && i_wdata == 32'h0 |=> !o_irq)
    else $error("irq with empty mask");
  cover property (o_nv_write);
  cover property ($fell(o_drive_permit_out[0]));
  cover property (o_irq);
endmodule

// [verification/sad_amp_model.sv]
/*
  Amplifier and motor model: moves each encoder one count per four clocks
  toward the sign of its drive. Assumes one clock; no motion without permit.
*/
`timescale 1ns/1ps
module sad_amp_model import sad_pkg::*; (
  // clock
  input wire logic i_clk,
  // amplifier inputs
  input wire logic [3:0] i_permit,
  input wire logic [3:0][DAC_W-1:0] i_drive,
  // encoder pins
  output logic [3:0] o_enc_a,
  output logic [3:0] o_enc_b
);
  logic [3:0][1:0] ph_q = '0;
  logic [1:0] div_q = '0;
  always_ff @(posedge i_clk) begin
    div_q <= div_q + 2'h1;
    // slow steps stay far inside the pin synchroniser
    for (int n = 0; n < 4; n++) begin
      if (div_q == 2'h0 && i_permit[n] && i_drive[n] != '0) begin
        ph_q[n] <= i_drive[n][DAC_W-1] ? ph_q[n] - 2'h1 : ph_q[n] + 2'h1;
      end
    end
  end
  always_comb begin
    for (int n = 0; n < 4; n++) begin
      o_enc_a[n] = ph_q[n][1] ^ ph_q[n][0];
      o_enc_b[n] = ph_q[n][1];
    end
  end
endmodule

// [verification/servo_axis_drive_safety_test.sv]
/*
  Bench for sad_axis_drive with the amplifier model on its far side.
  Assumes the plain register port and a servo tick of 8 clocks.
*/
`timescale 1ns/1ps
module servo_axis_drive_safety_test import sad_pkg::*; ;
  logic i_clk, i_reset, i_wr, i_rd, i_watchdog_trip, o_nv_write, o_irq;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata, i_nv_comm, o_nv_comm;
  logic [3:0] i_enc_a, i_enc_b, o_drive_permit_out;
  logic [3:0][DAC_W-1:0] o_analog_drive_out;
  int fail_count = 0;
  int checks_done = 0;
  int k;
  sad_axis_drive #(.NUM_AXES(4), .SERVO_TICK_CYCLES(8)) dut_u (.i_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_enc_a, .i_enc_b, .i_watchdog_trip, .o_drive_permit_out, .o_analog_drive_out, .i_nv_comm,
    .o_nv_write, .o_nv_comm, .o_irq);
  sad_amp_model amp_u (.i_clk, .i_permit(o_drive_permit_out), .i_drive(o_analog_drive_out), .o_enc_a(i_enc_a),
    .o_enc_b(i_enc_b));
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, s);
      fail_count++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), e, o_rdata);
  endtask
  // bounded wait; running out ends the run
  task automatic wait_p(input int n, input logic v, input int lim);
    k = 0;
    while (o_drive_permit_out[n] !== v && k < lim) begin
      @(posedge i_clk);
      #1 k++;
    end
    chk("permit", 32'(v), 32'(o_drive_permit_out[n]));
    if (o_drive_permit_out[n] !== v) give_verdict();
  endtask
  function automatic logic [7:0] ax(input int n, input logic [4:0] o);
    return A_AXIS_BASE + 8'(n << AXIS_STRIDE_SH) + 8'(o);
  endfunction
  initial begin
    i_reset = 1'b1;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_watchdog_trip = 1'b0;
    i_nv_comm = 32'h0000_0003;
    repeat (10) @(posedge i_clk);
    i_reset <= 1'b0;
    rchk(ax(0, O_LAG), LAG_LIMIT_RESET);
    rchk(ax(1, O_CLAMP), 32'(CLAMP_RESET_CODE));
    rchk(A_COMM, 32'h3);
    rchk(8'hFC, 32'h0);
    chk("permits", 32'h0, 32'(o_drive_permit_out));
    // shift 31 pins the angle near zero, so phase one stays at zero
    wr(A_COMM, 32'h0000_01F3);
    for (int n = 0; n < 2; n++) begin
      wr(ax(n, O_CLAMP), 32'h100);
      wr(ax(n, O_KPD), 32'h100);
      wr(ax(n, O_DIST), 32'h3E8);
      wr(A_CMD, 32'h100 << n);
      wr(A_CMD, 32'h1 << n);
      repeat (40) @(posedge i_clk);
      chk("phase two", 32'h1, 32'(o_analog_drive_out[2 + n] != '0));
      chk("idle phase two", 32'h1, 32'(o_analog_drive_out[3 - n] == '0));
      wr(A_CMD, 32'h10 << n);
      wait_p(n, 1'b0, 4);
    end
    wr(A_COMM, 32'h0);
    wr(A_NV_SAVE, 32'h1);
    chk("nv word", 32'h0, o_nv_comm);
    wr(A_CMD, 32'h100);
    wr(ax(0, O_DIST), 32'h3E8);
    repeat (40) @(posedge i_clk);
    rchk(ax(0, O_LEVEL), 32'h0);
    wr(A_CMD, 32'h1);
    repeat (40) @(posedge i_clk);
    rchk(ax(0, O_LEVEL), 32'h100);
    chk("drive out", 32'h100, 32'(o_analog_drive_out[0]));
    wr(A_CMD, 32'h10);
    wr(A_CMD, 32'h100);
    wr(ax(0, O_CTRL), 32'h2);
    wr(A_IRQ_MASK, 32'h1);
    wr(A_CMD, 32'h1);
    repeat (40) @(posedge i_clk);
    rchk(ax(0, O_LEVEL), 32'hFFFF_FF00);
    k = 0;
    while (o_irq !== 1'b1 && k < 8000) begin
      @(posedge i_clk);
      k++;
    end
    chk("irq", 32'h1, 32'(o_irq));
    if (o_irq !== 1'b1) give_verdict();
    chk("permit", 32'h1, 32'(o_drive_permit_out[0]));
    wr(ax(0, O_CTRL), 32'h3);
    wait_p(0, 1'b0, 20);
    wr(ax(0, O_CTRL), 32'h0);
    wr(A_CMD, 32'h100);
    wr(A_IRQ_STAT, 32'h1F);
    rchk(A_IRQ_STAT, 32'h0);
    chk("irq", 32'h0, 32'(o_irq));
    // pin held past the checker's six-sample window
    @(posedge i_clk);
    i_watchdog_trip <= 1'b1;
    wait_p(0, 1'b0, 8);
    repeat (6) @(posedge i_clk);
    i_watchdog_trip <= 1'b0;
    repeat (6) @(posedge i_clk);
    wr(A_CMD, 32'h100);
    wait_p(0, 1'b1, 4);
    rchk(A_IRQ_STAT, 32'h10);
    wr(A_IRQ_MASK, 32'h0);
    give_verdict();
  end
endmodule
bind sad_axis_drive sad_axis_props #(.NUM_AXES(NUM_AXES)) props_u (.i_clk, .i_reset, .i_addr, .i_wdata, .i_wr,
  .i_rd, .o_rdata, .i_watchdog_trip, .o_drive_permit_out, .o_analog_drive_out, .i_nv_comm, .o_nv_write, .o_nv_comm,
  .o_irq);
